// >>> core/pbc_pkg.sv
// Constants and types shared by both ends of the configuration access link
// Operation
// - Read-only bits ignore writes, strap-loaded at init
// - Write-one-clear: device sets, one clears, zero keeps
// - Sticky bits survive hot reset unchanged
// - Write-one-set: one sets, reads zero, device clears
// - Clear-on-read: read returns value, then clears
// - Reserved written as zero, read undefined
// - Undefined-after-reset bits depend on straps
// - Header format byte always reads bridge code
// - Device-specific registers start at offset 40h
// - Registers reachable only from primary interface
// - Master uses Type 0 configuration reads/writes
// - Address bits 7:2 carry dword offset
// - Byte enables select bytes; only enabled written
// - Config changes only when buses idle
package pbc_pkg;
	////////////////////////////////////////////////////////////////////////////
	// Link command codes
	localparam logic [3:0] PBC_CMD_CFG_RD = 4'hA;
	localparam logic [3:0] PBC_CMD_CFG_WR = 4'hB;
	localparam logic [1:0] PBC_TYPE0 = 2'h0;
	////////////////////////////////////////////////////////////////////////////
	// Device configuration map, byte offsets
	localparam logic [7:0] PBC_OFS_ID = 8'h00;
	localparam logic [7:0] PBC_OFS_HDR = 8'h0C;
	localparam logic [7:0] PBC_OFS_HDR_FMT = 8'h0E;
	localparam logic [7:0] PBC_HDR_FMT_VAL = 8'h01;
	localparam logic [7:0] PBC_OFS_DEV_BASE = 8'h40;
	localparam logic [7:0] PBC_OFS_CTRL = 8'h40;
	localparam logic [7:0] PBC_OFS_STAT = 8'h44;
	localparam logic [7:0] PBC_OFS_MISC = 8'h48;
	localparam logic [31:0] PBC_CTRL_RST = 32'h0000_0000;
	localparam logic [7:0] PBC_BYTE_RST = 8'h00;
	localparam logic [7:0] PBC_BYTE_FULL = 8'hFF;
	////////////////////////////////////////////////////////////////////////////
	// Host register map, byte offsets on APB
	localparam logic [11:0] PBC_H_ADDR = 12'h000;
	localparam logic [11:0] PBC_H_WDATA = 12'h004;
	localparam logic [11:0] PBC_H_CTRL = 12'h008;
	localparam logic [11:0] PBC_H_STAT = 12'h00C;
	localparam logic [11:0] PBC_H_RDATA = 12'h010;
	localparam logic [2:0] PBC_ABORT_CYC = 3'h5;
	////////////////////////////////////////////////////////////////////////////
	// State types
	typedef enum logic {PBC_D_IDLE, PBC_D_DATA} pbc_dst_t;
	typedef enum logic [1:0] {PBC_H_IDLE, PBC_H_ADR, PBC_H_DAT} pbc_hst_t;
endpackage : pbc_pkg

// >>> core/pbc_cfg_if.sv
// Configuration link between the host end and the bridge register bank
`timescale 1ns/1ps
interface pbc_cfg_if (
	input wire logic clk_i // Primary link clock
);
	logic frame_n;
	logic idsel;
	logic [3:0] primary_cmd_byte_enable_n;
	logic irdy_n;
	logic [31:0] host_ad;
	logic host_ad_oe;
	logic [31:0] dev_ad;
	logic dev_ad_oe;
	logic devsel_n;
	logic trdy_n;
	logic [31:0] ad;
	// Resolved address/data wire, idle level zero
	assign ad = dev_ad_oe ? dev_ad : (host_ad_oe ? host_ad : 32'h0000_0000);
	modport host (output frame_n, idsel, primary_cmd_byte_enable_n, irdy_n, host_ad, host_ad_oe,
		input ad, devsel_n, trdy_n);
	modport dev (input frame_n, idsel, primary_cmd_byte_enable_n, irdy_n, ad,
		output dev_ad, dev_ad_oe, devsel_n, trdy_n);
endinterface : pbc_cfg_if

// >>> core/pbc_dev.sv
// Bridge configuration register bank, device end of the link
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ps
module pbc_dev import pbc_pkg::*; #(
	parameter logic [31:0] ID_VALUE = 32'h0001_0002 // Identity word, value arbitrary
) (
	input wire logic clk_i, // Primary clock
	input wire logic rstn_i, // Power-on reset, active low
	pbc_cfg_if.dev link, // Primary configuration link
	input wire logic hot_rstn_i, // Hot reset pin, active low
	input wire logic [7:0] strap_i, // Strap pins
	input wire logic [7:0] evt_i, // Event pulses, set clearable flags
	input wire logic [7:0] err_i, // Error pulses, set sticky flags
	input wire logic [7:0] bell_clr_i, // Device clears doorbell bits
	output logic [31:0] ctrl_o, // Control word
	output logic [7:0] bell_o, // Doorbell bits
	output logic [7:0] rws_o // Sticky read/write byte
);
	pbc_dst_t st_q, st_d;
	logic [5:0] idx_q, idx_d;
	logic wr_q, wr_d;
	logic devsel_n_q, devsel_n_d, trdy_n_q, trdy_n_d, oe_q, oe_d;
	logic [31:0] ad_q, ad_d, ctrl_q, ctrl_d;
	logic [7:0] w1c_q, w1c_d, bell_q, bell_d, rc_q, rc_d, strap_q, strap_d;
	logic [7:0] w1cs_q, w1cs_d, rws_q, rws_d, rs_q, rs_d;
	logic strap_done_q, strap_done_d;
	logic [1:0] strap_arm_q, strap_arm_d;
	logic [7:0] strap_s1_q, strap_s2_q;
	logic hot_s1_q, hot_s2_q;
	logic claim, done;
	logic [3:0] be;
	logic [31:0] mask, wd;

	// Byte enables to a bit mask
	function automatic logic [31:0] be_mask(input logic [3:0] b);
		logic [31:0] m;
		m = 32'h0000_0000;
		for (int i = 0; i < 4; i++) begin
			m[i*8 +: 8] = {8{b[i]}};
		end
		return m;
	endfunction : be_mask

	// Read word by dword index; reserved and unmapped read zero
	function automatic logic [31:0] rd_word(input logic [5:0] i);
		case ({i, 2'b00})
			PBC_OFS_ID: rd_word = ID_VALUE;
			PBC_OFS_HDR: rd_word = {8'h00, PBC_HDR_FMT_VAL, 16'h0000};
			PBC_OFS_CTRL: rd_word = ctrl_q;
			PBC_OFS_STAT: rd_word = {rs_q, rws_q, w1cs_q, w1c_q};
			PBC_OFS_MISC: rd_word = {8'h00, strap_q, rc_q, 8'h00};
			default: rd_word = 32'h0000_0000;
		endcase
	endfunction : rd_word

	////////////////////////////////////////////////////////////////////////////
	// Address phase decode and completion
	assign be = ~link.primary_cmd_byte_enable_n;
	assign claim = !link.frame_n && link.idsel && link.ad[1:0] == PBC_TYPE0
		&& (link.primary_cmd_byte_enable_n == PBC_CMD_CFG_RD || link.primary_cmd_byte_enable_n == PBC_CMD_CFG_WR);
	assign done = st_q == PBC_D_DATA && !link.irdy_n;
	assign mask = be_mask(be) & {32{wr_q && done}};
	assign wd = link.ad;

	// Hot reset and strap pin synchronisers
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			hot_s1_q <= 1'b1;
			hot_s2_q <= 1'b1;
			strap_s1_q <= PBC_BYTE_RST;
			strap_s2_q <= PBC_BYTE_RST;
		end else begin
			hot_s1_q <= hot_rstn_i;
			hot_s2_q <= hot_s1_q;
			strap_s1_q <= strap_i;
			strap_s2_q <= strap_s1_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Link state and register next values
	always_comb begin
		st_d = st_q;
		idx_d = idx_q;
		wr_d = wr_q;
		devsel_n_d = devsel_n_q;
		trdy_n_d = trdy_n_q;
		oe_d = oe_q;
		ad_d = ad_q;
		case (st_q)
			PBC_D_IDLE: begin
				if (claim) begin
					st_d = PBC_D_DATA;
					idx_d = link.ad[7:2];
					wr_d = link.primary_cmd_byte_enable_n[0];
					devsel_n_d = 1'b0;
					trdy_n_d = 1'b0;
					oe_d = !link.primary_cmd_byte_enable_n[0];
					ad_d = rd_word(link.ad[7:2]);
				end
			end
			PBC_D_DATA: begin
				if (done) begin
					st_d = PBC_D_IDLE;
					devsel_n_d = 1'b1;
					trdy_n_d = 1'b1;
					oe_d = 1'b0;
					ad_d = 32'h0000_0000;
				end
			end
			default: st_d = PBC_D_IDLE;
		endcase
		// Plain read/write control word
		ctrl_d = idx_q == PBC_OFS_CTRL[7:2] ? (ctrl_q & ~mask) | (wd & mask) : ctrl_q;
		// Set wins over write-one clear
		w1c_d = w1c_q | evt_i;
		w1cs_d = w1cs_q | err_i;
		rws_d = rws_q;
		rs_d = rs_q | err_i;
		if (idx_q == PBC_OFS_STAT[7:2]) begin
			w1c_d = (w1c_q & ~(wd[7:0] & mask[7:0])) | evt_i;
			w1cs_d = (w1cs_q & ~(wd[15:8] & mask[15:8])) | err_i;
			rws_d = (rws_q & ~mask[23:16]) | (wd[23:16] & mask[23:16]);
		end
		// Doorbell: software sets, device clears; set wins
		bell_d = (bell_q & ~bell_clr_i);
		if (idx_q == PBC_OFS_MISC[7:2]) begin
			bell_d = bell_d | (wd[7:0] & mask[7:0]);
		end
		// Event counter, cleared by an enabled read, new events kept
		rc_d = rc_q;
		if (done && !wr_q && idx_q == PBC_OFS_MISC[7:2] && be[1]) begin
			rc_d = PBC_BYTE_RST;
		end
		if (evt_i != 8'h00 && rc_d != PBC_BYTE_FULL) begin
			rc_d = rc_d + 8'h01;
		end
		// Straps caught once the synchroniser has filled, never written
		strap_d = strap_done_q ? strap_q : strap_s2_q;
		strap_arm_d = {strap_arm_q[0], 1'b1};
		strap_done_d = strap_arm_q[1];
		// Hot reset returns only non-sticky state to defaults
		if (!hot_s2_q) begin
			st_d = PBC_D_IDLE;
			devsel_n_d = 1'b1;
			trdy_n_d = 1'b1;
			oe_d = 1'b0;
			ctrl_d = PBC_CTRL_RST;
			w1c_d = PBC_BYTE_RST;
			bell_d = PBC_BYTE_RST;
			rc_d = PBC_BYTE_RST;
		end
	end

	// Non-sticky state, cleared by power-on reset; hot reset clears only the link handshake and volatile registers
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			st_q <= PBC_D_IDLE;
			idx_q <= 6'h00;
			wr_q <= 1'b0;
			devsel_n_q <= 1'b1;
			trdy_n_q <= 1'b1;
			oe_q <= 1'b0;
			ad_q <= 32'h0000_0000;
			ctrl_q <= PBC_CTRL_RST;
			w1c_q <= PBC_BYTE_RST;
			bell_q <= PBC_BYTE_RST;
			rc_q <= PBC_BYTE_RST;
			strap_q <= PBC_BYTE_RST;
			strap_done_q <= 1'b0;
			strap_arm_q <= 2'h0;
		end else begin
			st_q <= st_d;
			idx_q <= idx_d;
			wr_q <= wr_d;
			devsel_n_q <= devsel_n_d;
			trdy_n_q <= trdy_n_d;
			oe_q <= oe_d;
			ad_q <= ad_d;
			ctrl_q <= ctrl_d;
			w1c_q <= w1c_d;
			bell_q <= bell_d;
			rc_q <= rc_d;
			strap_q <= strap_d;
			strap_done_q <= strap_done_d;
			strap_arm_q <= strap_arm_d;
		end
	end

	// Sticky state, cleared by power-on reset only
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			w1cs_q <= PBC_BYTE_RST;
			rws_q <= PBC_BYTE_RST;
			rs_q <= PBC_BYTE_RST;
		end else begin
			w1cs_q <= w1cs_d;
			rws_q <= rws_d;
			rs_q <= rs_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs; no secondary-side port reaches the bank
	assign link.devsel_n = devsel_n_q;
	assign link.trdy_n = trdy_n_q;
	assign link.dev_ad = ad_q;
	assign link.dev_ad_oe = oe_q;
	assign ctrl_o = ctrl_q;
	assign bell_o = bell_q;
	assign rws_o = rws_q;
endmodule : pbc_dev

// >>> core/pbc_host.sv
// Host end: APB-programmed master issuing configuration cycles
`timescale 1ns/1ps
module pbc_host import pbc_pkg::*; (
	input wire logic clk_i, // Primary clock
	input wire logic rstn_i, // Reset, active low
	input wire logic psel_i, // APB select
	input wire logic penable_i, // APB enable
	input wire logic pwrite_i, // APB direction
	input wire logic [11:0] paddr_i, // APB byte address
	input wire logic [31:0] pwdata_i, // APB write data
	output logic [31:0] prdata_o, // APB read data
	output logic pready_o, // APB ready
	output logic pslverr_o, // APB error, always low
	pbc_cfg_if.host link // Configuration link
);
	pbc_hst_t st_q, st_d;
	logic [5:0] off_q, off_d;
	logic [31:0] wdat_q, wdat_d, rdat_q, rdat_d, prdata_q, prdata_d, had_q, had_d;
	logic wr_q, wr_d, done_q, done_d, abt_q, abt_d, rdy_q, rdy_d, go;
	logic [3:0] be_q, be_d, cbe_n_q, cbe_n_d;
	logic frame_n_q, frame_n_d, irdy_n_q, irdy_n_d, idsel_q, idsel_d, oe_q, oe_d;
	logic [2:0] cnt_q, cnt_d;
	logic acc, busy;

	assign acc = psel_i && penable_i && rdy_q && pwrite_i;
	assign busy = st_q != PBC_H_IDLE;
	assign go = acc && paddr_i == PBC_H_CTRL && pwdata_i[0] && !busy;

	////////////////////////////////////////////////////////////////////////////
	// APB slave and link master next values
	always_comb begin
		rdy_d = psel_i && !penable_i;
		prdata_d = prdata_q;
		if (psel_i && !penable_i) begin
			case (paddr_i)
				PBC_H_ADDR: prdata_d = {24'h000000, off_q, 2'b00};
				PBC_H_WDATA: prdata_d = wdat_q;
				PBC_H_CTRL: prdata_d = {24'h000000, be_q, 2'b00, wr_q, 1'b0};
				PBC_H_STAT: prdata_d = {29'h00000000, abt_q, done_q, busy};
				PBC_H_RDATA: prdata_d = rdat_q;
				default: prdata_d = 32'h0000_0000;
			endcase
		end
		// Setup writes refused while a cycle runs
		off_d = off_q;
		wdat_d = wdat_q;
		wr_d = wr_q;
		be_d = be_q;
		if (acc && !busy) begin
			if (paddr_i == PBC_H_ADDR) off_d = pwdata_i[7:2];
			if (paddr_i == PBC_H_WDATA) wdat_d = pwdata_i;
			if (paddr_i == PBC_H_CTRL) begin
				wr_d = pwdata_i[1];
				be_d = pwdata_i[7:4];
			end
		end
		done_d = done_q;
		abt_d = abt_q;
		if (acc && paddr_i == PBC_H_STAT) begin
			done_d = done_q & ~pwdata_i[1];
			abt_d = abt_q & ~pwdata_i[2];
		end
		st_d = st_q;
		frame_n_d = frame_n_q;
		irdy_n_d = irdy_n_q;
		idsel_d = idsel_q;
		cbe_n_d = cbe_n_q;
		oe_d = oe_q;
		had_d = had_q;
		cnt_d = cnt_q;
		rdat_d = rdat_q;
		case (st_q)
			PBC_H_IDLE: begin
				if (go) begin
					st_d = PBC_H_ADR;
					frame_n_d = 1'b0;
					// Control bit 2 withholds the select to probe an unclaimed cycle
					idsel_d = !pwdata_i[2];
					cbe_n_d = pwdata_i[1] ? PBC_CMD_CFG_WR : PBC_CMD_CFG_RD;
					had_d = {24'h000000, off_q, PBC_TYPE0};
					oe_d = 1'b1;
				end
			end
			PBC_H_ADR: begin
				st_d = PBC_H_DAT;
				frame_n_d = 1'b1;
				idsel_d = 1'b0;
				irdy_n_d = 1'b0;
				cbe_n_d = ~be_q;
				had_d = wdat_q;
				oe_d = wr_q;
				cnt_d = 3'h0;
			end
			PBC_H_DAT: begin
				cnt_d = cnt_q + 3'h1;
				if (!link.trdy_n && !link.devsel_n) begin
					if (!wr_q) rdat_d = link.ad;
					done_d = 1'b1;
				end else if (cnt_q == PBC_ABORT_CYC - 3'h1) begin
					abt_d = 1'b1;
					done_d = 1'b1;
				end
				// Leave on completion or timeout, whatever the status flags hold
				if (!link.trdy_n && !link.devsel_n || cnt_q == PBC_ABORT_CYC - 3'h1) begin
					st_d = PBC_H_IDLE;
					irdy_n_d = 1'b1;
					cbe_n_d = 4'hF;
					oe_d = 1'b0;
					had_d = 32'h0000_0000;
				end
			end
			default: st_d = PBC_H_IDLE;
		endcase
	end

	// Register everything
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			st_q <= PBC_H_IDLE;
			off_q <= 6'h00;
			wdat_q <= 32'h0000_0000;
			rdat_q <= 32'h0000_0000;
			prdata_q <= 32'h0000_0000;
			had_q <= 32'h0000_0000;
			wr_q <= 1'b0;
			done_q <= 1'b0;
			abt_q <= 1'b0;
			rdy_q <= 1'b0;
			be_q <= 4'h0;
			cbe_n_q <= 4'hF;
			frame_n_q <= 1'b1;
			irdy_n_q <= 1'b1;
			idsel_q <= 1'b0;
			oe_q <= 1'b0;
			cnt_q <= 3'h0;
		end else begin
			st_q <= st_d;
			off_q <= off_d;
			wdat_q <= wdat_d;
			rdat_q <= rdat_d;
			prdata_q <= prdata_d;
			had_q <= had_d;
			wr_q <= wr_d;
			done_q <= done_d;
			abt_q <= abt_d;
			rdy_q <= rdy_d;
			be_q <= be_d;
			cbe_n_q <= cbe_n_d;
			frame_n_q <= frame_n_d;
			irdy_n_q <= irdy_n_d;
			idsel_q <= idsel_d;
			oe_q <= oe_d;
			cnt_q <= cnt_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs
	assign prdata_o = prdata_q;
	assign pready_o = rdy_q;
	assign pslverr_o = 1'b0;
	assign link.frame_n = frame_n_q;
	assign link.irdy_n = irdy_n_q;
	assign link.idsel = idsel_q;
	assign link.primary_cmd_byte_enable_n = cbe_n_q;
	assign link.host_ad = had_q;
	assign link.host_ad_oe = oe_q;
endmodule : pbc_host

// >>> tb/pbc_link_asserts.sv
// Concurrent checks on the configuration link between host end and bank
`timescale 1ns/1ps
module pbc_link_asserts import pbc_pkg::*; (
	input wire logic clk_i, // Link clock
	input wire logic rstn_i, // Reset, active low
	input wire logic frame_n, // Address phase
	input wire logic idsel, // Config select
	input wire logic [3:0] primary_cmd_byte_enable_n, // Command or enables
	input wire logic irdy_n, // Host ready
	input wire logic host_ad_oe, // Host drives
	input wire logic dev_ad_oe, // Device drives
	input wire logic devsel_n, // Device claim
	input wire logic trdy_n, // Device ready
	input wire logic [31:0] ad // Resolved wire
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rstn_i);
	logic hit;
	logic rd;
	////////////////////////////////////////
	// Decode of a claimable address phase
	assign hit = !frame_n && idsel && ad[1:0] == 2'h0
		&& primary_cmd_byte_enable_n inside {PBC_CMD_CFG_RD, PBC_CMD_CFG_WR};
	assign rd = hit && primary_cmd_byte_enable_n == PBC_CMD_CFG_RD;
	////////////////////////////////////////
	// Claim, drive and release checks
	claim_cause_a: assert property ($fell(devsel_n) |-> $past(hit)) else $error("claim without select");
	claim_time_a: assert property (hit |=> !devsel_n && !trdy_n) else $error("claim late");
	no_select_a: assert property (!frame_n && !idsel |=> devsel_n [*2]) else $error("claim without idsel");
	hdr_code_a: assert property (rd && ad[7:2] == 6'h03 |=> ad[23:16] == PBC_HDR_FMT_VAL)
		else $error("header format byte wrong");
	read_drive_a: assert property (rd |=> dev_ad_oe && !host_ad_oe) else $error("read data not driven");
	dev_quiet_a: assert property (devsel_n |-> !dev_ad_oe) else $error("device drives unclaimed");
	release_a: assert property (!trdy_n && !irdy_n |=> trdy_n && devsel_n) else $error("claim not released");
	frame_one_a: assert property ($fell(frame_n) |=> $rose(frame_n)) else $error("address phase too long");
	no_fight_a: assert property (!(dev_ad_oe && host_ad_oe)) else $error("both ends drive");
	cover property (rd ##1 !trdy_n);
	cover property (hit && !rd);
	cover property (rd && ad[7:2] == 6'h03);
	cover property (!frame_n && !idsel);
endmodule : pbc_link_asserts

// >>> tb/pci_bridge_config_space_access_tb.sv
// Testbench driving configuration cycles from APB into the register bank
`timescale 1ns/1ps
module pci_bridge_config_space_access_tb import pbc_pkg::*;;
	logic clk_i = 1'h0;
	logic rstn_i = 1'h0;
	logic hot_rstn_i = 1'h1;
	logic psel_i = 1'h0;
	logic penable_i = 1'h0;
	logic pwrite_i = 1'h0;
	logic [11:0] paddr_i = 12'h000;
	logic [31:0] pwdata_i = 32'h0000_0000;
	logic [7:0] strap_i = 8'h5A;
	logic [7:0] evt_i = 8'h00, err_i = 8'h00, bell_clr_i = 8'h00;
	logic [31:0] prdata_o, ctrl_o, r;
	logic pready_o;
	logic [7:0] bell_o, rws_o;
	int error_cnt = 0;
	int checked = 0;
	////////////////////////////////////////
	// Both ends joined by the link
	pbc_cfg_if u_pbc_cfg_if (.clk_i(clk_i));
	pbc_host u_pbc_host (.clk_i(clk_i), .rstn_i(rstn_i), .psel_i(psel_i), .penable_i(penable_i),
		.pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
		.pready_o(pready_o), .pslverr_o(), .link(u_pbc_cfg_if));
	pbc_dev u_pbc_dev (.clk_i(clk_i), .rstn_i(rstn_i), .link(u_pbc_cfg_if), .hot_rstn_i(hot_rstn_i),
		.strap_i(strap_i), .evt_i(evt_i), .err_i(err_i), .bell_clr_i(bell_clr_i), .ctrl_o(ctrl_o),
		.bell_o(bell_o), .rws_o(rws_o));
	pbc_link_asserts u_pbc_link_asserts (.clk_i(clk_i), .rstn_i(rstn_i), .frame_n(u_pbc_cfg_if.frame_n),
		.idsel(u_pbc_cfg_if.idsel), .primary_cmd_byte_enable_n(u_pbc_cfg_if.primary_cmd_byte_enable_n),
		.irdy_n(u_pbc_cfg_if.irdy_n), .host_ad_oe(u_pbc_cfg_if.host_ad_oe), .dev_ad_oe(u_pbc_cfg_if.dev_ad_oe),
		.devsel_n(u_pbc_cfg_if.devsel_n), .trdy_n(u_pbc_cfg_if.trdy_n), .ad(u_pbc_cfg_if.ad));
	////////////////////////////////////////
	// Clock, 40 ns period
	initial begin
		forever #20 clk_i = ~clk_i;
	end
	////////////////////////////////////////
	// Verdict and compare helpers
	task print_verdict();
		if (error_cnt == 0 && checked > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : print_verdict
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch at %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// One APB transfer, held until pready is seen
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge clk_i);
		psel_i <= 1'h1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clk_i);
		penable_i <= 1'h1;
		do @(posedge clk_i); while (pready_o !== 1'h1);
		q = prdata_o;
		psel_i <= 1'h0;
		penable_i <= 1'h0;
	endtask : apb
	// One configuration cycle through the host registers
	task cfg(input logic w, input logic [7:0] o, input logic [3:0] be, input logic [31:0] d, output logic [31:0] q);
		logic [31:0] s;
		apb(1'h1, PBC_H_ADDR, {24'h000000, o}, s);
		apb(1'h1, PBC_H_WDATA, d, s);
		apb(1'h1, PBC_H_CTRL, {24'h000000, be, 2'h0, w, 1'h1}, s);
		do apb(1'h0, PBC_H_STAT, 32'h0000_0000, s); while (s[1] !== 1'h1);
		apb(1'h1, PBC_H_STAT, 32'h0000_0006, s);
		apb(1'h0, PBC_H_RDATA, 32'h0000_0000, q);
	endtask : cfg
	task cmp(input logic [7:0] o, input logic [31:0] m, input logic [31:0] exp);
		logic [31:0] q;
		cfg(1'h0, o, 4'hF, 32'h0000_0000, q);
		chk(q & m, exp);
	endtask : cmp
	task pulse(input logic [7:0] e, input logic [7:0] x);
		@(posedge clk_i);
		evt_i <= e;
		err_i <= x;
		@(posedge clk_i);
		evt_i <= 8'h00;
		err_i <= 8'h00;
	endtask : pulse
	////////////////////////////////////////
	// Watchdog against a hung handshake
	initial begin
		repeat (20000) @(posedge clk_i);
		error_cnt++;
		print_verdict();
	end
	////////////////////////////////////////
	// Main sequence
	initial begin
		repeat (10) @(posedge clk_i);
		rstn_i <= 1'h1;
		cmp(PBC_OFS_HDR, 32'h00FF_0000, {8'h00, PBC_HDR_FMT_VAL, 16'h0000});
		cfg(1'h1, PBC_OFS_HDR, 4'hF, 32'hFFFF_FFFF, r);
		cmp(PBC_OFS_HDR, 32'h00FF_0000, {8'h00, PBC_HDR_FMT_VAL, 16'h0000});
		cfg(1'h1, PBC_OFS_CTRL, 4'hF, 32'hFFFF_FFFF, r);
		cfg(1'h1, PBC_OFS_CTRL, 4'h5, 32'h0000_0000, r);
		cmp(PBC_OFS_CTRL, 32'hFFFF_FFFF, 32'hFF00_FF00);
		chk(ctrl_o, 32'hFF00_FF00);
		cfg(1'h1, PBC_OFS_MISC, 4'h5, 32'h00FF_0081, r);
		chk({24'h000000, bell_o}, 32'h0000_0081);
		cmp(PBC_OFS_MISC, 32'h00FF_FFFF, 32'h005A_0000);
		@(posedge clk_i);
		bell_clr_i <= 8'h01;
		@(posedge clk_i);
		bell_clr_i <= 8'h00;
		repeat (2) @(posedge clk_i);
		chk({24'h000000, bell_o}, 32'h0000_0080);
		pulse(8'h01, 8'h03);
		pulse(8'h01, 8'h00);
		cmp(PBC_OFS_MISC, 32'h0000_FF00, 32'h0000_0200);
		cmp(PBC_OFS_MISC, 32'h0000_FF00, 32'h0000_0000);
		cfg(1'h1, PBC_OFS_STAT, 4'hF, 32'hFFA5_0100, r);
		cmp(PBC_OFS_STAT, 32'hFFFF_FFFF, 32'h03A5_0201);
		chk({24'h000000, rws_o}, 32'h0000_00A5);
		pulse(8'h10, 8'h00);
		// Hot reset spares the sticky bytes and clears control, doorbell, event flags and counter
		hot_rstn_i <= 1'h0;
		repeat (4) @(posedge clk_i);
		hot_rstn_i <= 1'h1;
		repeat (3) @(posedge clk_i);
		cmp(PBC_OFS_STAT, 32'hFFFF_FFFF, 32'h03A5_0200);
		chk({24'h000000, rws_o}, 32'h0000_00A5);
		chk(ctrl_o, 32'h0000_0000);
		chk({24'h000000, bell_o}, 32'h0000_0000);
		cmp(PBC_OFS_MISC, 32'h0000_FF00, 32'h0000_0000);
		// Cycle without configuration select stays unclaimed and aborts
		apb(1'h1, PBC_H_CTRL, 32'h0000_00F5, r);
		do apb(1'h0, PBC_H_STAT, 32'h0000_0000, r); while (r[1] !== 1'h1);
		chk(r, 32'h0000_0006);
		apb(1'h1, PBC_H_STAT, 32'h0000_0006, r);
		apb(1'h0, PBC_H_STAT, 32'h0000_0000, r);
		chk(r, 32'h0000_0000);
		// Power-on reset clears the sticky bytes too; an unmapped host address reads zero
		rstn_i <= 1'h0;
		repeat (3) @(posedge clk_i);
		rstn_i <= 1'h1;
		cmp(PBC_OFS_STAT, 32'hFFFF_FFFF, 32'h0000_0000);
		apb(1'h0, 12'h020, 32'h0000_0000, r);
		chk(r, 32'h0000_0000);
		print_verdict();
	end
endmodule : pci_bridge_config_space_access_tb
